// ---- logic/tfl_pkg.sv ----
// Constants, register map and state types of the T1 data-link, loopback and interrupt block.
// Assumes a 20 MHz system clock that oversamples the 2.048 MHz serial bit clock.
package tfl_pkg;

  // System clock and serial frame timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned HALF_SEC_NS = 500000000;
  localparam int unsigned FRAMES_PER_HALF = HALF_SEC_NS / FRAME_NS;
  localparam int unsigned FRAME_HZ = 8000;
  localparam int unsigned FDL_BPS = 4000;
  localparam int unsigned FRAMES_PER_FDL_BIT = FRAME_HZ / FDL_BPS;
  localparam logic [1:0] FDL_DIV_LAST = 2'(FRAMES_PER_FDL_BIT - 1);

  // APB register byte offsets
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_CTRL_VIEW = 8'h0C;
  localparam logic [7:0] OFS_STATE_VIEW = 8'h10;

  // Event bits shared by status, clear and enable
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_CTRL = 0;
  localparam int unsigned EVT_SEC = 1;
  localparam int unsigned EVT_LINE = 2;

  // Control stream channel allocation
  localparam logic [4:0] CH_BOM = 5'h07;
  localparam logic [4:0] CH_CTRL = 5'h0B;
  localparam logic [4:0] CH_LOOP = 5'h0F;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Data-link flag and loopback code patterns (codes sent from bit 4 downward, flag from bit 7)
  localparam logic [7:0] FLAG_BYTE = 8'hFF;
  localparam logic [4:0] ACT_PATTERN = 5'h01;
  localparam logic [2:0] ACT_LEN = 3'h5;
  localparam logic [4:0] DEACT_PATTERN = 5'h04;
  localparam logic [2:0] DEACT_LEN = 3'h3;

  // Loopback control word, low two bits
  typedef enum logic [1:0] {
    LB_NORMAL = 2'b00,
    LB_PAYLOAD = 2'b01,
    LB_ACT_CODE = 2'b10,
    LB_DEACT_CODE = 2'b11
  } tfl_loop_t;

  // Interrupt group states, Gray along disarmed -> armed -> pending
  typedef enum logic [1:0] {
    GRP_DISARMED = 2'b00,
    GRP_ARMED = 2'b01,
    GRP_PENDING = 2'b11
  } tfl_grp_t;

  // Main control word carried in the control stream
  typedef struct packed {
    logic [5:0] spare;
    logic ack;
    logic bos;
  } tfl_ctrl_t;

  // Whole state of the block
  typedef struct packed {
    logic run;
    logic bclk_prev;
    logic fp_prev;
    logic [7:0] bit_cnt;
    logic [7:0] shift;
    tfl_ctrl_t ctrl;
    logic [7:0] bit_oriented_message;
    logic [7:0] loopw;
    logic [15:0] half_cnt;
    logic one_sec;
    logic [1:0] fdl_div;
    logic [3:0] fdl_idx;
    logic [15:0] fdl_word;
    logic fdl_bit;
    logic [2:0] code_idx;
    logic dst;
    tfl_grp_t [1:0] grp;
    logic line_oe_n;
    logic [EVT_W-1:0] sts;
    logic [EVT_W-1:0] ena;
    logic host_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tfl_state_t;

  // Reset value of the state: idle lines high, interrupt line released
  localparam tfl_state_t STATE_RST = '{
    bclk_prev: 1'b1,
    fp_prev: 1'b1,
    fdl_bit: 1'b1,
    dst: 1'b1,
    line_oe_n: 1'b1,
    grp: '{GRP_DISARMED, GRP_DISARMED},
    default: '0
  };

endpackage

// ---- logic/tfl_fdl_loop_irq.sv ----
// Data-link insertion, outgoing stream source selection, line interrupt and one-second timer.
// Assumes the serial bit clock, frame pulse and streams are synchronous inputs to pclk,
// which must run well above twice the bit clock rate.
//
// How it works
// - Control stream timed by bit clock; stream select retimed on pclk
// - Low reset suspends every function
// - Select low passes link input through untouched
// - Select high blocks the link input
// - Bit-oriented output sends FF flag then message
// - Square wave: low half second, high half
// - Interrupt pulls open-drain line low only
// - Acknowledge low releases the interrupt line
// - Re-arm group only once its sources idle
// - Outgoing stream from normal or loop input
// - Loopback word picks the stream source
// - Code modes fill payload with loopback code
// - Control word taken from channel 11
// - Message byte taken from channel 7
// - Loopback word taken from channel 15
`timescale 1ns/1ps

module tfl_fdl_loop_irq
  import tfl_pkg::*;
#(
  parameter int unsigned FRAMES_HALF = FRAMES_PER_HALF,
  parameter int unsigned SRC_W = 4
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial timing and streams
  input wire logic serial_bit_clock_in,
  input wire logic frame_pulse_in_n,
  input wire logic control_stream_in_b,
  input wire logic payload_stream_in_normal,
  input wire logic payload_stream_in_loop,
  output logic payload_stream_out,
  // Facility data link
  input wire logic link_msg_in,
  output logic link_msg_out,
  // Interrupt sources, open-drain line and host interrupt
  input wire logic [SRC_W-1:0] grp1_src,
  input wire logic [SRC_W-1:0] grp2_src,
  output logic line_irq_n,
  output logic line_irq_oe_n,
  output logic host_irq,
  // Timer
  output logic one_second_out
);

  tfl_state_t st_reg;
  tfl_state_t st_next;
  logic bit_edge;
  logic frame_tick;
  logic [4:0] chan;
  logic [7:0] rx_byte;
  logic payload_ch;
  tfl_loop_t mode;
  logic code_mode;
  logic [2:0] code_len;
  logic code_bit;
  logic [15:0] word_cur;
  logic [1:0][SRC_W-1:0] src;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] clr;
  logic apb_setup;
  logic apb_acc;

  assign src = {grp2_src, grp1_src};

  // Next-state logic of the whole block
  always_comb begin
    st_next = st_reg;
    evt = '0;
    clr = '0;
    st_next.run = 1'b1;
    st_next.bclk_prev = serial_bit_clock_in;
    bit_edge = serial_bit_clock_in & ~st_reg.bclk_prev;
    frame_tick = bit_edge & ~frame_pulse_in_n & st_reg.fp_prev;
    chan = st_reg.bit_cnt[7:3];
    rx_byte = {st_reg.shift[6:0], control_stream_in_b};
    mode = tfl_loop_t'(st_reg.loopw[1:0]);
    code_mode = (mode == LB_ACT_CODE) || (mode == LB_DEACT_CODE);
    code_len = (mode == LB_ACT_CODE) ? ACT_LEN : DEACT_LEN;
    code_bit = (mode == LB_ACT_CODE) ? ACT_PATTERN[3'(3'h4 - st_reg.code_idx)]
                                     : DEACT_PATTERN[3'(3'h4 - st_reg.code_idx)];
    // Every fourth slot carries no payload, leaving 24 of 32
    payload_ch = (chan[1:0] != 2'b00);
    word_cur = (st_reg.fdl_idx == 4'h0) ? {FLAG_BYTE, st_reg.bit_oriented_message} : st_reg.fdl_word;

    // Frame counter and control channel capture on the bit clock rising edge
    if (bit_edge) begin
      st_next.fp_prev = frame_pulse_in_n;
      st_next.shift = rx_byte;
      st_next.bit_cnt = frame_pulse_in_n ? st_reg.bit_cnt + 8'h01 : 8'h00;
      if (st_reg.bit_cnt[2:0] == LAST_BIT) begin
        if (chan == CH_CTRL) begin
          st_next.ctrl = tfl_ctrl_t'(rx_byte);
          evt[EVT_CTRL] = (rx_byte != st_reg.ctrl);
        end
        if (chan == CH_BOM) begin
          st_next.bit_oriented_message = rx_byte;
        end
        if (chan == CH_LOOP) begin
          st_next.loopw = rx_byte;
        end
      end
    end

    // Half-second count of frame pulses; the wave starts low after reset
    if (frame_tick) begin
      if (st_reg.half_cnt == 16'(FRAMES_HALF - 1)) begin
        st_next.half_cnt = 16'h0000;
        st_next.one_sec = ~st_reg.one_sec;
        evt[EVT_SEC] = 1'b1;
      end else begin
        st_next.half_cnt = st_reg.half_cnt + 16'h0001;
      end
    end

    // Bit-oriented sender: one bit per two frames, flag byte first
    if (!st_reg.ctrl.bos) begin
      st_next.fdl_idx = 4'h0;
      st_next.fdl_bit = 1'b1;
      st_next.fdl_div = 2'h0;
    end else if (frame_tick) begin
      if (st_reg.fdl_div == FDL_DIV_LAST) begin
        st_next.fdl_div = 2'h0;
        st_next.fdl_bit = word_cur[15];
        st_next.fdl_word = {word_cur[14:0], 1'b0};
        st_next.fdl_idx = st_reg.fdl_idx + 4'h1;
      end else begin
        st_next.fdl_div = st_reg.fdl_div + 2'h1;
      end
    end

    // Outgoing stream source; registered so the pin never glitches
    case (mode)
      LB_NORMAL: st_next.dst = payload_stream_in_normal;
      LB_PAYLOAD: st_next.dst = payload_stream_in_loop;
      default: st_next.dst = payload_ch ? code_bit : 1'b1;
    endcase
    if (!code_mode) begin
      st_next.code_idx = 3'h0;
    end else if (bit_edge && payload_ch) begin
      st_next.code_idx = (st_reg.code_idx == 3'(code_len - 3'h1)) ? 3'h0
                                                                 : st_reg.code_idx + 3'h1;
    end

    // Interrupt groups; arming needs the acknowledge bit high and sources quiet
    for (int g = 0; g < 2; g++) begin
      case (st_reg.grp[g])
        GRP_DISARMED: begin
          if (st_reg.ctrl.ack && (src[g] == '0)) begin
            st_next.grp[g] = GRP_ARMED;
          end
        end
        GRP_ARMED: begin
          if (!st_reg.ctrl.ack) begin
            st_next.grp[g] = GRP_DISARMED;
          end else if (src[g] != '0) begin
            st_next.grp[g] = GRP_PENDING;
            evt[EVT_LINE] = 1'b1;
          end
        end
        GRP_PENDING: begin
          if (!st_reg.ctrl.ack) begin
            st_next.grp[g] = GRP_DISARMED;
          end
        end
        default: st_next.grp[g] = GRP_DISARMED;
      endcase
    end
    // The line is driven only while a group is pending; otherwise it floats
    st_next.line_oe_n = ~((st_next.grp[0] == GRP_PENDING) ||
                          (st_next.grp[1] == GRP_PENDING));

    // APB: answer is prepared in setup so pready rises in the first access cycle
    apb_setup = psel & ~penable;
    apb_acc = psel & penable & st_reg.pready;
    st_next.pready = apb_setup;
    if (apb_setup) begin
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      case (paddr)
        OFS_STATUS: st_next.prdata = 32'(st_reg.sts);
        OFS_CLEAR: st_next.prdata = 32'h0000_0000;
        OFS_ENABLE: st_next.prdata = 32'(st_reg.ena);
        OFS_CTRL_VIEW: st_next.prdata = {8'h00, st_reg.loopw, st_reg.bit_oriented_message, st_reg.ctrl};
        OFS_STATE_VIEW: st_next.prdata = {st_reg.half_cnt, 11'h000, st_reg.grp[1],
                                          st_reg.grp[0], st_reg.one_sec};
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (apb_acc && pwrite) begin
      if (paddr == OFS_ENABLE) begin
        st_next.ena = pwdata[EVT_W-1:0];
      end
      if (paddr == OFS_CLEAR) begin
        clr = pwdata[EVT_W-1:0];
      end
    end
    // A new event wins over a clear in the same cycle
    st_next.sts = (st_reg.sts & ~clr) | evt;
    st_next.host_irq = |(st_next.sts & st_next.ena);
  end

  // State register; reset suspends everything and floats the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign payload_stream_out = st_reg.dst;
  assign one_second_out = st_reg.one_sec;
  assign host_irq = st_reg.host_irq;
  assign line_irq_oe_n = st_reg.line_oe_n;
  // Open drain: only ever drives low, the enable decides
  assign line_irq_n = 1'b0;
  // The pass-through path is not retimed, so it and the constant line_irq_n are the outputs without a flop
  assign link_msg_out = !st_reg.run ? 1'b1 :
                        st_reg.ctrl.bos ? st_reg.fdl_bit : link_msg_in;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_bos_on;
    st_reg.run && st_reg.ctrl.bos;
  endsequence

  sequence s_fdl_shift;
    frame_tick && (st_reg.fdl_div == FDL_DIV_LAST) && (st_reg.fdl_idx < 4'h8);
  endsequence

  sequence s_rearm(int g);
    (st_reg.grp[g] == GRP_DISARMED) ##1 (st_reg.grp[g] == GRP_ARMED);
  endsequence

  a_bit_edge_gate: assert property (!bit_edge |=> $stable(st_reg.bit_cnt))
    else $error("bit counter moved without a bit clock edge");
  a_link_pass: assert property (st_reg.run && !st_reg.ctrl.bos |-> link_msg_out == link_msg_in)
    else $error("link input not passed through");
  a_link_block: assert property (s_bos_on |-> link_msg_out == st_reg.fdl_bit)
    else $error("link input leaked in bit-oriented mode");
  a_flag_lead: assert property (s_bos_on ##0 s_fdl_shift |=> st_reg.fdl_bit)
    else $error("flag byte bit not high");
  a_sec_toggle: assert property (frame_tick && st_reg.half_cnt == 16'(FRAMES_HALF - 1)
                                 |=> one_second_out != $past(one_second_out))
    else $error("one-second wave did not toggle");
  a_sec_hold: assert property (!frame_tick |=> $stable(one_second_out))
    else $error("one-second wave moved without a frame pulse");
  a_irq_pull: assert property ((st_reg.grp[0] == GRP_PENDING) || (st_reg.grp[1] == GRP_PENDING)
                               |-> !line_irq_oe_n && !line_irq_n)
    else $error("pending group not driving the line");
  a_ack_release: assert property (!st_reg.ctrl.ack |=> line_irq_oe_n)
    else $error("line not released after acknowledge low");
  a_rearm_quiet: assert property (s_rearm(0) |-> $past(grp1_src) == '0 && $past(st_reg.ctrl.ack))
    else $error("group re-armed with active source");
  a_loop_select: assert property (st_reg.run && mode == LB_PAYLOAD
                                  |=> payload_stream_out == $past(payload_stream_in_loop))
    else $error("payload loopback source not selected");
  a_normal_select: assert property (st_reg.run && mode == LB_NORMAL
                                    |=> payload_stream_out == $past(payload_stream_in_normal))
    else $error("normal source not selected");
  a_code_fill: assert property (code_mode && payload_ch |=> payload_stream_out == $past(code_bit))
    else $error("payload channel lacks loopback code");
  a_ctrl_take: assert property (bit_edge && st_reg.bit_cnt == {CH_CTRL, LAST_BIT}
                                |=> st_reg.ctrl == $past(rx_byte))
    else $error("control word not taken from its channel");
  a_bom_take: assert property (bit_edge && st_reg.bit_cnt == {CH_BOM, LAST_BIT}
                               |=> st_reg.bit_oriented_message == $past(rx_byte))
    else $error("message byte not taken from its channel");
  a_loop_take: assert property (bit_edge && st_reg.bit_cnt == {CH_LOOP, LAST_BIT}
                                |=> st_reg.loopw == $past(rx_byte))
    else $error("loopback word not taken from its channel");
  a_reset_idle: assert property (!st_reg.run |-> line_irq_oe_n && st_reg.half_cnt == 16'h0000
                                 && payload_stream_out && link_msg_out)
    else $error("paths not idle straight after reset");

endmodule

// ---- testbench/tfl_framer_model.sv ----
// Far-side model: framer and host sending bit clock, frame pulse and control stream.
// Assumes pclk at 20 MHz; the bit clock is pclk divided by ten and runs free.
`timescale 1ns/1ps

module tfl_framer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel contents to send
  input wire logic [7:0] ctrl_byte,
  input wire logic [7:0] bom_byte,
  input wire logic [7:0] loop_byte,
  // Serial timing and control stream
  output logic bit_clk,
  output logic frame_n,
  output logic ctrl_data
);
  logic [3:0] div_reg;
  logic [7:0] idx_reg;
  logic [7:0] nidx;
  logic [7:0] nbyte;

  // Byte of the channel that the next bit belongs to; unused channels idle high
  assign nidx = idx_reg + 8'd1;
  always_comb begin
    case (nidx[7:3])
      5'd11: nbyte = ctrl_byte;
      5'd7: nbyte = bom_byte;
      5'd15: nbyte = loop_byte;
      default: nbyte = 8'hFF;
    endcase
  end

  // Data and frame pulse change on the falling bit clock, so they are steady at the rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'd0;
      idx_reg <= 8'd254;
      bit_clk <= 1'b0;
      frame_n <= 1'b1;
      ctrl_data <= 1'b1;
    end else begin
      div_reg <= (div_reg == 4'd9) ? 4'd0 : div_reg + 4'd1;
      if (div_reg == 4'd4) begin
        bit_clk <= 1'b1;
      end
      if (div_reg == 4'd9) begin
        bit_clk <= 1'b0;
        idx_reg <= nidx;
        frame_n <= (nidx != 8'hFF);
        ctrl_data <= nbyte[3'd7 - nidx[2:0]];
      end
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the data-link, stream select, interrupt and timer block.
// Assumes the far-side model above; one frame is 2560 pclk cycles.
`timescale 1ns/1ps

module testbench;
  import tfl_pkg::*;
  localparam int FC = 2560;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, ctrl_b, bom_b, loop_b;
  logic [31:0] pwdata, prdata, rd;
  logic bclk, fp_n, cst, in_n, in_l, dst, lin, lout, irq_n, irq_oe_n, hirq, osec;
  logic [3:0] g1, g2;
  int n_errors, samples_checked;

  // Clock and time-zero input values
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, in_n, in_l, lin} = '0;
    {paddr, pwdata, g1, g2, ctrl_b, bom_b, loop_b} = '0;
  end

  tfl_framer_model fm_u (.pclk(pclk), .presetn(presetn), .ctrl_byte(ctrl_b), .bom_byte(bom_b),
    .loop_byte(loop_b), .bit_clk(bclk), .frame_n(fp_n), .ctrl_data(cst));

  tfl_fdl_loop_irq #(.FRAMES_HALF(4), .SRC_W(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_bit_clock_in(bclk),
    .frame_pulse_in_n(fp_n), .control_stream_in_b(cst), .payload_stream_in_normal(in_n),
    .payload_stream_in_loop(in_l), .payload_stream_out(dst), .link_msg_in(lin),
    .link_msg_out(lout), .grp1_src(g1), .grp2_src(g2), .line_irq_n(irq_n),
    .line_irq_oe_n(irq_oe_n), .host_irq(hirq), .one_second_out(osec));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Channel bytes reload once a frame, so a change needs a frame plus a channel to land
  task automatic frames(input int n);
    repeat (n * FC + 200) @(posedge pclk);
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16) begin
      @(posedge pclk);
      k++;
    end
    chk(pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Register defaults and an unmapped address
  task automatic t_regs;
    apb(0, OFS_ENABLE, 0);
    chk(rd, 0);
    apb(0, OFS_CLEAR, 0);
    chk(rd, 0);
    apb(1, 8'h14, 32'hFFFF_FFFF);
    chk(err, 1);
  endtask

  // High half of the square wave spans exactly four frames
  task automatic t_sec;
    int n;
    chk(osec, 0);
    n = 0;
    while (osec !== 1'b1 && n < 6 * FC) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (osec === 1'b1 && n < 6 * FC) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 4 * FC);
  endtask

  // Pass-through is combinational; bit-oriented mode blocks input and starts on flag ones
  task automatic t_link;
    int bad;
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      lin <= v[0];
      @(negedge pclk);
      chk(lout, v);
    end
    ctrl_b <= 8'h01;
    frames(1);
    bad = 0;
    repeat (3 * FC) begin
      @(posedge pclk);
      lin <= ~lin;
      @(negedge pclk);
      if (lout !== 1'b1) bad++;
    end
    chk(bad, 0);
    ctrl_b <= 8'h00;
  endtask

  // Every loopback mode: normal, payload loop, activate and deactivate codes
  task automatic t_stream;
    int bad;
    int zc[4];
    for (int m = 0; m < 4; m++) begin
      loop_b <= m[7:0];
      frames(1);
      bad = 0;
      zc[m] = 0;
      for (int i = 0; i < FC; i++) begin
        @(posedge pclk);
        in_n <= m[1] | i[0];
        in_l <= m[1] | ~i[0];
        @(negedge pclk);
        if (i > 0 && dst !== (m[0] ? i[0] : ~i[0])) bad++;
        if (dst === 1'b0) zc[m]++;
      end
      if (!m[1]) chk(bad, 0);
    end
    chk(zc[2] > zc[3], 1);
    chk(zc[3] > 0, 1);
  endtask

  // Interrupt assert, mask, clear, acknowledge release and group re-arm
  task automatic t_irq;
    apb(1, OFS_ENABLE, 32'h0000_0005);
    apb(0, OFS_ENABLE, 0);
    chk(rd, 5);
    apb(1, OFS_ENABLE, 32'h0000_0004);
    ctrl_b <= 8'h02;
    frames(1);
    g1 <= 4'h1;
    repeat (3) @(posedge pclk);
    chk(irq_oe_n, 0);
    chk(irq_n, 0);
    chk(hirq, 1);
    apb(1, OFS_ENABLE, 0);
    chk(hirq, 0);
    apb(1, OFS_ENABLE, 32'h0000_0004);
    apb(1, OFS_CLEAR, 32'h0000_0004);
    apb(0, OFS_STATUS, 0);
    chk(rd[2], 0);
    chk(hirq, 0);
    ctrl_b <= 8'h00;
    frames(1);
    chk(irq_oe_n, 1);
    ctrl_b <= 8'h02;
    frames(1);
    chk(irq_oe_n, 1);
    apb(0, OFS_STATE_VIEW, 0);
    chk(rd[4:1], 4'b0100);
    g1 <= 4'h0;
    repeat (3) @(posedge pclk);
    g1 <= 4'h8;
    repeat (3) @(posedge pclk);
    chk(irq_oe_n, 0);
  endtask

  // Reset in mid-run with the interrupt pending
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq_oe_n, 1);
    chk(hirq, 0);
    chk({osec, dst, lout}, 3'b011);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(irq_oe_n, 1);
    chk(osec, 0);
  endtask

  // Watchdog sized above the roughly sixty thousand cycles the tests need
  initial begin
    repeat (90000) @(posedge pclk);
    n_errors++;
    wrap_up;
  end

  // Main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_sec;
    t_link;
    t_stream;
    t_irq;
    t_reset;
    wrap_up;
  end
endmodule
